// [srh_host.sv]
// read host for an asynchronous sram with triggered sensing
// assumes sram pins are wired to the o_ and i_dq ports; dq is resolved
// outside from o_dq_oe
//
// Functional notes
// - address held while chip selected, except between reads of the address method
// - address stable when selects become active
// - controls settled before address change
// - never switch selects, oe, address together
// - one access method while chip selected
// - selects delayed until address settled
`timescale 1ns/1ns
`default_nettype none
module srh_host
    import srh_pkg::*;
(
    // clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_sys_rst,
    // user read request
    input  wire logic              i_req,
    input  wire logic [1:0]        i_mode,
    input  wire logic [ADDR_W-1:0] i_addr,
    output logic                   o_ready,
    output logic [DATA_W-1:0]      o_rd_data,
    output logic                   o_rd_valid,
    // sram pins
    output logic [ADDR_W-1:0]      o_addr,
    output logic                   o_cs_n,
    output logic                   o_cs,
    output logic                   o_oe_n,
    output logic                   o_we_n,
    input  wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0]      o_dq_out,
    output logic                   o_dq_oe
);
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ADDR    = 3'h1,
        ST_OEN     = 3'h2,
        ST_SEL     = 3'h3,
        ST_ACCA    = 3'h4,
        ST_DESEL_O = 3'h5,
        ST_DESEL_C = 3'h6
    } srh_state_e;

    localparam int ACCA_BASE = (ADDR_TO_VALID_CYC > MIN_READ_CYCLE_CYC) ?
                               ADDR_TO_VALID_CYC : MIN_READ_CYCLE_CYC;
    localparam logic [CNT_W-1:0] C_SETTLE = CNT_W'(ADDR_SETTLE_CYC + 1);
    localparam logic [CNT_W-1:0] C_GAP    = CNT_W'(GAP_CYC);
    localparam logic [CNT_W-1:0] C_EN     = CNT_W'(ENABLE_TO_VALID_CYC);
    localparam logic [CNT_W-1:0] C_EN_RD  =
        CNT_W'(ENABLE_TO_VALID_CYC + SYNC_CYC);
    localparam logic [CNT_W-1:0] C_OE_RD  =
        CNT_W'(OE_TO_VALID_CYC + SYNC_CYC);
    localparam logic [CNT_W-1:0] C_ACCA   = CNT_W'(ACCA_BASE + SYNC_CYC);

    srh_state_e        state;
    srh_state_e        next_state;
    srh_mode_e         mode;
    srh_mode_e         next_mode;
    logic [ADDR_W-1:0] req_addr;
    logic [ADDR_W-1:0] next_req_addr;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic              cs_on;
    logic              next_cs_on;
    logic              oe_on;
    logic              next_oe_on;
    logic              held;
    logic              next_held;
    logic              pend;
    logic              next_pend;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] next_rd_data;
    logic              rd_valid;
    logic              next_rd_valid;
    logic              tmr_load;
    logic [CNT_W-1:0]  tmr_count;
    logic              tmr_done;
    logic              capture;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    srh_mode_e         in_mode;

    // unknown mode code falls back to a chip-enable read
    assign in_mode = (i_mode == 2'h3) ? SRH_MODE_CE : srh_mode_e'(i_mode);

    srh_timer #(
        .W       (CNT_W)
    ) i_srh_timer (
        .i_mclk  (i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_load  (tmr_load),
        .i_count (tmr_count),
        .o_done  (tmr_done)
    );

    // data pins pass two flops before the capture reads them
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= i_dq;
            dq_s2 <= dq_s1;
        end
    end

    // capture at the end of the last wait of each method
    assign capture = tmr_done && (
        (state == ST_OEN  && mode == SRH_MODE_OE) ||
        (state == ST_SEL  && mode != SRH_MODE_OE) ||
        (state == ST_ACCA));

    // sequencer: one pin group changes per step
    always_comb begin
        next_state    = state;
        next_mode     = mode;
        next_req_addr = req_addr;
        next_addr     = addr;
        next_cs_on    = cs_on;
        next_oe_on    = oe_on;
        next_held     = held;
        next_pend     = pend;
        next_rd_data  = rd_data;
        next_rd_valid = 1'b0;
        tmr_load      = 1'b0;
        tmr_count     = C_GAP;
        unique case (state)
            ST_IDLE: begin
                if (i_req) begin
                    next_mode     = in_mode;
                    next_req_addr = i_addr;
                    tmr_load      = 1'b1;
                    if (held && in_mode == SRH_MODE_ADDR) begin
                        next_addr  = i_addr;
                        next_state = ST_ACCA;
                        tmr_count  = C_ACCA;
                    end else if (held) begin
                        // leave address method before another one
                        next_oe_on = 1'b0;
                        next_held  = 1'b0;
                        next_pend  = 1'b1;
                        next_state = ST_DESEL_O;
                    end else begin
                        next_state = ST_ADDR;
                        tmr_count  = C_SETTLE;
                    end
                end
            end
            ST_ADDR: begin
                next_addr = req_addr;
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    if (mode == SRH_MODE_OE) begin
                        next_cs_on = 1'b1;
                        next_state = ST_SEL;
                        tmr_count  = C_EN;
                    end else begin
                        next_oe_on = 1'b1;
                        next_state = ST_OEN;
                    end
                end
            end
            ST_OEN: begin
                if (tmr_done && mode != SRH_MODE_OE) begin
                    next_cs_on = 1'b1;
                    next_state = ST_SEL;
                    tmr_load   = 1'b1;
                    tmr_count  = C_EN_RD;
                end
            end
            ST_SEL: begin
                if (tmr_done && mode == SRH_MODE_OE) begin
                    next_oe_on = 1'b1;
                    next_state = ST_OEN;
                    tmr_load   = 1'b1;
                    tmr_count  = C_OE_RD;
                end
            end
            ST_ACCA: begin
                next_state = tmr_done ? ST_IDLE : ST_ACCA;
            end
            ST_DESEL_O: begin
                if (tmr_done) begin
                    next_cs_on = 1'b0;
                    next_state = ST_DESEL_C;
                    tmr_load   = 1'b1;
                end
            end
            ST_DESEL_C: begin
                if (tmr_done) begin
                    next_pend  = 1'b0;
                    next_state = pend ? ST_ADDR : ST_IDLE;
                    tmr_load   = pend;
                    tmr_count  = C_SETTLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (capture) begin
            next_rd_data  = dq_s2;
            next_rd_valid = 1'b1;
            if (state != ST_ACCA) begin
                tmr_load = 1'b1;
                tmr_count = C_GAP;
                if (mode == SRH_MODE_ADDR) begin
                    // stay selected for following address reads
                    next_held  = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    next_oe_on = 1'b0;
                    next_state = ST_DESEL_O;
                end
            end
        end
    end

    // register sequencer state
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state    <= ST_IDLE;
            mode     <= SRH_MODE_CE;
            req_addr <= '0;
            addr     <= '0;
            cs_on    <= 1'b0;
            oe_on    <= 1'b0;
            held     <= 1'b0;
            pend     <= 1'b0;
            rd_data  <= '0;
            rd_valid <= 1'b0;
        end else begin
            state    <= next_state;
            mode     <= next_mode;
            req_addr <= next_req_addr;
            addr     <= next_addr;
            cs_on    <= next_cs_on;
            oe_on    <= next_oe_on;
            held     <= next_held;
            pend     <= next_pend;
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // pin and user outputs; host never drives dq, reads only
    assign o_ready    = (state == ST_IDLE);
    assign o_rd_data  = rd_data;
    assign o_rd_valid = rd_valid;
    assign o_addr     = addr;
    assign o_cs_n     = !cs_on;
    assign o_cs       = cs_on;
    assign o_oe_n     = !oe_on;
    assign o_we_n     = 1'b1;
    assign o_dq_out   = '0;
    assign o_dq_oe    = 1'b0;

    // address settled one cycle, then selects rise
    sequence s_addr_quiet;
        $stable(addr);
    endsequence
    sequence s_sel_rise;
        $rose(cs_on);
    endsequence

    property p_addr_hold;
        @(posedge i_mclk) disable iff (i_sys_rst)
        cs_on && $past(cs_on) && !held && state != ST_ACCA |-> $stable(addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved during chip-enable read");

    property p_setup;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_sel_rise |-> s_addr_quiet;
    endproperty
    a_setup: assert property (p_setup)
        else $error("address not stable at select rise");

    property p_ctrl_first;
        @(posedge i_mclk) disable iff (i_sys_rst)
        $changed(addr) |-> !cs_on || ($past(cs_on) && $past(oe_on));
    endproperty
    a_ctrl_first: assert property (p_ctrl_first)
        else $error("address changed before controls settled");

    property p_no_cs_oe;
        @(posedge i_mclk) disable iff (i_sys_rst)
        $changed(cs_on) |-> $stable(oe_on) && $stable(addr);
    endproperty
    a_no_cs_oe: assert property (p_no_cs_oe)
        else $error("select switched with oe or address");

    property p_no_oe_addr;
        @(posedge i_mclk) disable iff (i_sys_rst)
        $changed(oe_on) |-> $stable(addr);
    endproperty
    a_no_oe_addr: assert property (p_no_oe_addr)
        else $error("oe switched with address");

    property p_one_method;
        @(posedge i_mclk) disable iff (i_sys_rst)
        // method is judged while the chip is selected and driving
        cs_on && $past(cs_on) && oe_on |-> $stable(mode);
    endproperty
    a_one_method: assert property (p_one_method)
        else $error("access method changed while selected");

    property p_settle;
        @(posedge i_mclk) disable iff (i_sys_rst)
        s_sel_rise |-> $past(addr, 2) == addr;
    endproperty
    a_settle: assert property (p_settle)
        else $error("select rose before address settled");

    property p_no_drive;
        @(posedge i_mclk) disable iff (i_sys_rst)
        !o_dq_oe && o_we_n;
    endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("host drove data or write strobe");
endmodule
`default_nettype wire

// [srh_pkg_note_unused.sv]
// holds no code; the shared package lives beside the wait timer
// (file intentionally minimal)

// [srh_sram_model.sv]
// behavioural sram with triggered sensing, the far side of srh_host
// assumes pins driven by the host; dq is resolved by the bench
`timescale 1ns/1ns
`default_nettype none
module srh_sram_model #(
    parameter int T_ACC_NS = 15,
    parameter int SENSE_NS = 5
) (
    // sram pins
    input  wire logic [18:0] i_addr,
    input  wire logic        i_cs_n,
    input  wire logic        i_cs,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    output logic [7:0]       o_dq
);
    logic       sel;
    logic       drive;
    logic [7:0] sensed = 8'h00;
    logic [7:0] last   = 8'h00;
    time        t_start = 0;
    // both selects active; drive only in an enabled read
    assign sel   = !i_cs_n && i_cs;
    assign drive = sel && !i_oe_n && i_we_n;
    // sense on select assertion or address change while selected
    always @(posedge sel or i_addr) begin
        if (sel) begin
            // a change past the window opens a separate read
            if ($time > t_start + SENSE_NS) t_start = $time;
            // array content is a fixed pattern of the address
            sensed <= #T_ACC_NS i_addr[7:0] ^ {i_addr[18:16], i_addr[12:8]};
        end
    end
    // released pins show the inverse of the last driven byte
    always @(sensed or drive) begin
        if (drive) last = sensed;
    end
    assign o_dq = drive ? sensed : ~last;
endmodule
`default_nettype wire

// [srh_timer.sv]
// shared constants for the read-trigger sram host and its wait timer
// assumes one 10 mhz clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
package srh_pkg;
    // clock period and the figure that every ns-based cycle count is derived from
    localparam int CLK_NS               = 100;
    // pin widths and the wait timer count width
    localparam int ADDR_W               = 19;
    localparam int DATA_W               = 8;
    localparam int CNT_W                = 8;
    // device read timing, ns; plain defaults, no figure is given here
    localparam int T_ENABLE_TO_VALID_NS = 25;
    localparam int T_OE_TO_VALID_NS     = 10;
    localparam int T_ADDR_TO_VALID_NS   = 25;
    localparam int T_MIN_READ_CYCLE_NS  = 25;
    // address settle margin before chip select, ns
    localparam int T_ADDR_SETTLE_NS     = 10;
    // least times round up, never below one cycle
    localparam int ENABLE_TO_VALID_CYC  =
        (T_ENABLE_TO_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int OE_TO_VALID_CYC      =
        (T_OE_TO_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_TO_VALID_CYC    =
        (T_ADDR_TO_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int MIN_READ_CYCLE_CYC   =
        (T_MIN_READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_SETTLE_CYC      =
        (T_ADDR_SETTLE_NS + CLK_NS - 1) / CLK_NS;
    // two-flop data synchroniser delay and the gap between pin changes
    localparam int SYNC_CYC             = 2;
    localparam int GAP_CYC              = 1;
    // read access methods
    typedef enum logic [1:0] {
        SRH_MODE_ADDR = 2'h0,
        SRH_MODE_CE   = 2'h1,
        SRH_MODE_OE   = 2'h2
    } srh_mode_e;
endpackage

module srh_timer
    import srh_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    // load and status
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_done
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    // load a count, then run down to zero and rest there
    always_comb begin
        next_cnt = cnt;
        if (i_load) begin
            next_cnt = i_count;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
    end

    // register the count
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // done comes from the register only; the user decides its load from
    // done, so a term in i_load here would close a combinational loop
    assign o_done = (cnt == '0);
endmodule
`default_nettype wire

// [test_srh_host.sv]
// self-checking bench for srh_host against srh_sram_model
// assumes srh_pkg, srh_host and srh_sram_model are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_srh_host;
    import srh_pkg::*;
    logic              i_mclk    = 1'b0;
    logic              i_sys_rst = 1'b1;
    logic              i_req     = 1'b0;
    logic [1:0]        i_mode    = 2'h0;
    logic [ADDR_W-1:0] i_addr    = 19'h00000;
    logic [DATA_W-1:0] i_dq;
    logic [DATA_W-1:0] sram_dq;
    logic              o_ready;
    logic [DATA_W-1:0] o_rd_data;
    logic              o_rd_valid;
    logic [ADDR_W-1:0] o_addr;
    logic              o_cs_n;
    logic              o_cs;
    logic              o_oe_n;
    logic              o_we_n;
    logic [DATA_W-1:0] o_dq_out;
    logic              o_dq_oe;
    logic [ADDR_W-1:0] p_addr;
    logic              p_cs_n;
    logic              p_oe_n;
    int                n_fail   = 0;
    int                compares = 0;
    // clock of 100 ns
    initial forever #50 i_mclk = ~i_mclk;
    // dq wire chosen by the host's o_dq_oe alone
    assign i_dq = o_dq_oe ? o_dq_out : sram_dq;
    srh_host i_srh_host (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_req(i_req), .i_mode(i_mode), .i_addr(i_addr), .o_ready(o_ready),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_addr(o_addr),
        .o_cs_n(o_cs_n), .o_cs(o_cs), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
        .i_dq(i_dq), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
    srh_sram_model i_srh_sram_model (.i_addr(o_addr), .i_cs_n(o_cs_n),
        .i_cs(o_cs), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .o_dq(sram_dq));
    // expected array content for an address
    function automatic logic [7:0] pat(input logic [18:0] a);
        return a[7:0] ^ {a[18:16], a[12:8]};
    endfunction
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge i_mclk);
        #1;
    endtask
    task automatic wait_ready();
        int k;
        for (k = 0; k < 20 && o_ready !== 1'b1; k++) tick();
        if (o_ready !== 1'b1) begin
            n_fail++;
            summarize();
        end
    endtask
    // count edges from take until the read answer
    task automatic wait_valid(output int n);
        for (n = 1; n <= 30; n++) begin
            tick();
            if (o_rd_valid === 1'b1) return;
        end
        n_fail++;
        summarize();
    endtask
    task automatic issue(input logic [1:0] mode, input logic [18:0] a);
        wait_ready();
        i_mode = mode;
        i_addr = a;
        i_req  = 1'b1;
        tick();
        i_req  = 1'b0;
    endtask
    task automatic read(input logic [1:0] mode, input logic [18:0] a,
                        input int lat);
        int n;
        issue(mode, a);
        wait_valid(n);
        if (lat > 0) check("latency", lat, n);
        check("rd_data", pat(a), o_rd_data);
    endtask
    // pin groups never switch together; fixed pins hold
    always begin
        tick();
        if (i_sys_rst === 1'b0) begin
            check("one_group", 1, ((o_cs_n !== p_cs_n) + (o_oe_n !== p_oe_n)
                + (o_addr !== p_addr)) <= 1);
            check("cs_pair", !o_cs_n, o_cs);
            check("dq_out", 0, o_dq_out);
            check("we_n", 1, o_we_n);
            check("dq_oe", 0, o_dq_oe);
        end
        p_addr = o_addr;
        p_cs_n = o_cs_n;
        p_oe_n = o_oe_n;
    end
    task automatic t_reset();
        check("rst_cs_n", 1, o_cs_n);
        check("rst_oe_n", 1, o_oe_n);
        check("rst_addr", 0, o_addr);
        check("rst_valid", 0, o_rd_valid);
        check("rst_ready", 1, o_ready);
    endtask
    task automatic t_ce_read();
        read(SRH_MODE_CE, 19'h12345, 9);
        wait_ready();
        check("ce_desel", 1, o_cs_n);
        check("ce_oe_off", 1, o_oe_n);
        read(2'h3, 19'h05555, 9);
    endtask
    task automatic t_oe_read();
        read(SRH_MODE_OE, 19'h7FFFF, 9);
        read(SRH_MODE_OE, 19'h00000, 9);
    endtask
    task automatic t_addr_reads();
        read(SRH_MODE_ADDR, 19'h00001, 0);
        wait_ready();
        check("held_cs", 1, o_cs);
        check("held_oe", 0, o_oe_n);
        read(SRH_MODE_ADDR, 19'h00002, 4);
        read(SRH_MODE_ADDR, 19'h40000, 4);
        read(SRH_MODE_ADDR, 19'h40000, 0);
        read(SRH_MODE_CE, 19'h2AAAA, 0);
    endtask
    // a request while busy is ignored
    task automatic t_refused();
        int n;
        issue(SRH_MODE_CE, 19'h01234);
        tick();
        i_addr = 19'h7ABCD;
        i_req  = 1'b1;
        tick();
        i_req  = 1'b0;
        wait_valid(n);
        check("busy_data", pat(19'h01234), o_rd_data);
        check("busy_addr", 19'h01234, o_addr);
        for (n = 0; n < 12; n++) begin
            tick();
            if (o_rd_valid === 1'b1) check("extra_valid", 0, 1);
        end
    endtask
    // reset in mid-read returns the pins to idle
    task automatic t_mid_reset();
        issue(SRH_MODE_OE, 19'h03C3C);
        tick();
        tick();
        i_sys_rst = 1'b1;
        tick();
        tick();
        t_reset();
        i_sys_rst = 1'b0;
        read(SRH_MODE_CE, 19'h03C3C, 9);
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge i_mclk);
        #1;
        t_reset();
        i_sys_rst = 1'b0;
        t_ce_read();
        t_oe_read();
        t_addr_reads();
        t_refused();
        t_mid_reset();
        summarize();
    end
endmodule
`default_nettype wire
